// *** hw/sbs_top.sv ***
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module sbs_top (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [sbs_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output      logic [31:0]                 prdata,
	output      logic                        pready,
	output      logic                        pslverr,
	input  wire logic                        data_line_in,
	output      sbs_pkg::sbs_pin_t           data_line_pin,
	output      sbs_pkg::sbs_pin_t           clock_line_pin
);

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic       sel_tsc, sel_rsc, sel_rcr, sel_dvl, sel_dvh, sel_thr, sel_rhr, sel_flg;
	logic       hit, acc, wr, rd_rhr;
	logic [7:0] rd_mux;

	assign sel_tsc = paddr == sbs_pkg::OFS_TSC;
	assign sel_rsc = paddr == sbs_pkg::OFS_RSC;
	assign sel_rcr = paddr == sbs_pkg::OFS_RCR;
	assign sel_dvl = paddr == sbs_pkg::OFS_DVL;
	assign sel_dvh = paddr == sbs_pkg::OFS_DVH;
	assign sel_thr = paddr == sbs_pkg::OFS_THR;
	assign sel_rhr = paddr == sbs_pkg::OFS_RHR;
	assign sel_flg = paddr == sbs_pkg::OFS_FLG;
	assign hit     = sel_tsc | sel_rsc | sel_rcr | sel_dvl | sel_dvh | sel_thr | sel_rhr
	               | sel_flg;
	assign acc     = psel & penable;
	assign wr      = acc & pwrite & hit;
	assign rd_rhr  = acc & ~pwrite & sel_rhr;
	assign pready  = acc;                 // zero wait states
	assign pslverr = acc & ~hit;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [7:0] tsc_q, rsc_q, rcr_q, dvl_q, dvh_q, thr_q, rhr_q;
	logic       thr9_q, thr_full_q, fer_q, r9d_q, rrdy_q;
	logic       pen, ckm, mst, pol, sync_tx, tx_go, brk_done, brk_req;
	logic       wake_clr, rrdy_set;

	assign pen     = rsc_q[sbs_pkg::RSC_PEN];
	assign ckm     = tsc_q[sbs_pkg::TSC_CKM];
	assign mst     = pen & ckm & tsc_q[sbs_pkg::TSC_MCS];
	assign pol     = rcr_q[sbs_pkg::RCR_POL];
	assign sync_tx = mst & ~rsc_q[sbs_pkg::RSC_SRX] & ~rsc_q[sbs_pkg::RSC_CRX];
	assign tx_go   = tsc_q[sbs_pkg::TSC_TEN] & (sync_tx | (pen & ~ckm));
	assign brk_req = tsc_q[sbs_pkg::TSC_BRK] & ~brk_done;

	// ------------------------------------------------------------
	// bit timing from the divisor pair
	// ------------------------------------------------------------
	logic [15:0]               div_eff;
	logic [2:0]                shamt;
	logic [sbs_pkg::CNT_W-1:0] bit_cyc, half_cyc;

	assign div_eff  = rcr_q[sbs_pkg::RCR_WID] ? {dvh_q, dvl_q} : {8'h00, dvl_q};
	assign shamt    = ckm ? sbs_pkg::SH_FAST
	                : ({rcr_q[sbs_pkg::RCR_WID], tsc_q[sbs_pkg::TSC_RHS]} == 2'b11)
	                ? sbs_pkg::SH_FAST
	                : (rcr_q[sbs_pkg::RCR_WID] | tsc_q[sbs_pkg::TSC_RHS])
	                ? sbs_pkg::SH_MID : sbs_pkg::SH_SLOW;
	assign bit_cyc  = ({8'h00, div_eff} + 24'h1) << shamt;
	assign half_cyc = bit_cyc >> 1;

	// ------------------------------------------------------------
	// transmit engine signals
	// ------------------------------------------------------------
	sbs_pkg::sbs_tx_st_t       tx_st_q;
	logic [sbs_pkg::CNT_W-1:0] tx_cnt_q;
	logic [sbs_pkg::FRM_W-1:0] tsh_q, tsh_ld;
	logic [3:0]                tbits_q, tbits_ld;
	logic                      brk_act_q, sclk_q;
	logic                      tx_tick, step_end, tx_done, tx_load, tx_idle;

	assign tx_tick  = tx_cnt_q == 24'h1;
	assign step_end = tx_tick & (tx_st_q == sbs_pkg::TX_ASYNC || tx_st_q == sbs_pkg::TX_TRAIL);
	assign tx_done  = step_end & (tbits_q == 4'h1);
	assign tx_idle  = tx_st_q == sbs_pkg::TX_IDLE;
	assign tx_load  = (tx_idle | tx_done) & thr_full_q & tx_go;
	assign brk_done = tx_done & brk_act_q;

	// load image: lsb first, ninth bit last, async framed, clocked unframed
	assign tsh_ld   = ckm ? {5'h1f, tsc_q[sbs_pkg::TSC_NBE] ? thr9_q : 1'b1, thr_q}
	                : brk_req ? {1'b1, {(sbs_pkg::FRM_W-1){1'b0}}}
	                : tsc_q[sbs_pkg::TSC_NBE] ? {3'h7, 1'b1, thr9_q, thr_q, 1'b0}
	                : {4'hf, 1'b1, thr_q, 1'b0};
	assign tbits_ld = ckm ? (tsc_q[sbs_pkg::TSC_NBE] ? sbs_pkg::LEN_S9 : sbs_pkg::LEN_S8)
	                : brk_req ? sbs_pkg::LEN_BRK
	                : tsc_q[sbs_pkg::TSC_NBE] ? sbs_pkg::LEN_A9 : sbs_pkg::LEN_A8;

	// ------------------------------------------------------------
	// receive signals
	// ------------------------------------------------------------
	sbs_pkg::sbs_rx_st_t       rx_st_q;
	logic [sbs_pkg::CNT_W-1:0] rx_cnt_q;
	logic [3:0]                rbits_q;
	logic [8:0]                rsh_q;
	logic                      rx_s1_q, rx_s2_q, rx_prev_q;
	logic                      rx_on, rx_tick, fall, rise, wake_idle;

	assign rx_on     = pen & ~ckm & rsc_q[sbs_pkg::RSC_CRX] & ~rcr_q[sbs_pkg::RCR_WAK];
	assign rx_tick   = rx_cnt_q == 24'h1;
	assign fall      = rx_prev_q & ~rx_s2_q;
	assign rise      = ~rx_prev_q & rx_s2_q;
	assign wake_idle = pen & ~ckm & rcr_q[sbs_pkg::RCR_WAK] & (rx_st_q == sbs_pkg::RX_IDLE);
	assign wake_clr  = wake_idle & rise;
	assign rrdy_set  = (wake_idle & fall)
	                 | (rx_st_q == sbs_pkg::RX_STOP & rx_tick);

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	logic [7:0] tsc_d, rsc_d, rcr_d;

	assign tsc_d = (wr & sel_tsc) ? (pwdata[7:0] & sbs_pkg::TSC_WMSK) : tsc_q;
	assign rsc_d = (wr & sel_rsc) ? (pwdata[7:0] & sbs_pkg::RSC_WMSK) : rsc_q;
	assign rcr_d = (wr & sel_rcr) ? (pwdata[7:0] & sbs_pkg::RCR_WMSK) : rcr_q;

	// control registers; hardware clears lose to a software set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tsc_q <= sbs_pkg::REG_RST;
			rsc_q <= sbs_pkg::REG_RST;
			rcr_q <= sbs_pkg::REG_RST;
			dvl_q <= sbs_pkg::REG_RST;
			dvh_q <= sbs_pkg::REG_RST;
		end else begin
			tsc_q <= tsc_d;
			rcr_q <= rcr_d;
			rsc_q <= rsc_d;
			if (brk_done & ~(wr & sel_tsc))
				tsc_q[sbs_pkg::TSC_BRK] <= 1'b0;
			if (wake_clr & ~(wr & sel_rcr))
				rcr_q[sbs_pkg::RCR_WAK] <= 1'b0;
			if (wr & sel_dvl)
				dvl_q <= pwdata[7:0];
			if (wr & sel_dvh)
				dvh_q <= pwdata[7:0];
		end
	end

	// transmit holding register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			thr_q      <= sbs_pkg::REG_RST;
			thr9_q     <= 1'b0;
			thr_full_q <= 1'b0;
		end else begin
			if (wr & sel_thr) begin
				thr_q  <= pwdata[7:0];
				thr9_q <= tsc_q[sbs_pkg::TSC_NTB];
			end
			thr_full_q <= pen & ((wr & sel_thr) | (thr_full_q & ~tx_load));
		end
	end

	// read data captured in the setup phase
	always_comb begin
		rd_mux = 8'h00;
		if (sel_tsc)
			rd_mux = {tsc_q[7:2], tx_idle, tsc_q[0]};
		if (sel_rsc)
			rd_mux = {rsc_q[7:3], fer_q, 1'b0, r9d_q};
		if (sel_rcr)
			rd_mux = {1'b0, rx_st_q == sbs_pkg::RX_IDLE, 1'b0, rcr_q[4:0]};
		if (sel_dvl)
			rd_mux = dvl_q;
		if (sel_dvh)
			rd_mux = dvh_q;
		if (sel_rhr)
			rd_mux = rhr_q;
		if (sel_flg)
			rd_mux = {6'h00, rrdy_q, ~thr_full_q};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			prdata <= 32'h0;
		else if (psel & ~penable & ~pwrite)
			prdata <= {24'h000000, rd_mux};
	end

	// ------------------------------------------------------------
	// transmit engine
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_st_q   <= sbs_pkg::TX_IDLE;
			tx_cnt_q  <= '0;
			tsh_q     <= '1;
			tbits_q   <= 4'h0;
			brk_act_q <= 1'b0;
			sclk_q    <= 1'b0;
		end else if (~pen) begin
			tx_st_q   <= sbs_pkg::TX_IDLE;
			tsh_q     <= '1;
			brk_act_q <= 1'b0;
			sclk_q    <= pol;
		end else if (tx_load) begin
			tx_st_q   <= ckm ? sbs_pkg::TX_LEAD : sbs_pkg::TX_ASYNC;
			tx_cnt_q  <= ckm ? half_cyc : bit_cyc;
			tsh_q     <= tsh_ld;
			tbits_q   <= tbits_ld;
			brk_act_q <= ~ckm & brk_req;
			sclk_q    <= ~pol;
		end else if (tx_done) begin
			tx_st_q   <= sbs_pkg::TX_IDLE;
			tsh_q     <= '1;
			brk_act_q <= 1'b0;
			sclk_q    <= pol;
		end else if (step_end) begin
			tx_st_q   <= ckm ? sbs_pkg::TX_LEAD : sbs_pkg::TX_ASYNC;
			tx_cnt_q  <= ckm ? half_cyc : bit_cyc;
			tsh_q     <= {1'b1, tsh_q[sbs_pkg::FRM_W-1:1]};
			tbits_q   <= tbits_q - 4'h1;
			sclk_q    <= ~pol;
		end else if (tx_st_q == sbs_pkg::TX_LEAD && tx_tick) begin
			tx_st_q   <= sbs_pkg::TX_TRAIL;
			tx_cnt_q  <= half_cyc;
			sclk_q    <= pol;
		end else if (tx_idle) begin
			sclk_q    <= pol;
		end else begin
			tx_cnt_q  <= tx_cnt_q - 24'h1;
		end
	end

	// pins: master drives the clock, and the data line too when no receive enable is set; async drives serial out
	assign clock_line_pin.out  = ckm ? sclk_q : tsh_q[0];
	assign clock_line_pin.oe_n = ~(mst | (pen & ~ckm));
	assign data_line_pin.out   = tsh_q[0];
	assign data_line_pin.oe_n  = ~sync_tx;

	// ------------------------------------------------------------
	// receive line synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_s1_q   <= 1'b1;
			rx_s2_q   <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			rx_s1_q   <= data_line_in;
			rx_s2_q   <= rx_s1_q;
			rx_prev_q <= rx_s2_q;
		end
	end

	// ------------------------------------------------------------
	// async receiver: feeds the break test by flags and data
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_st_q  <= sbs_pkg::RX_IDLE;
			rx_cnt_q <= '0;
			rbits_q  <= 4'h0;
			rsh_q    <= 9'h000;
		end else if (~rx_on) begin
			rx_st_q  <= sbs_pkg::RX_IDLE;
		end else begin
			unique case (rx_st_q)
				sbs_pkg::RX_IDLE: begin
					if (fall) begin
						rx_st_q  <= sbs_pkg::RX_START;
						rx_cnt_q <= half_cyc;
					end
				end
				sbs_pkg::RX_START: begin
					if (rx_tick) begin
						rx_st_q  <= rx_s2_q ? sbs_pkg::RX_IDLE : sbs_pkg::RX_DATA;
						rx_cnt_q <= bit_cyc;
						rbits_q  <= rsc_q[sbs_pkg::RSC_R9E] ? sbs_pkg::LEN_S9 : sbs_pkg::LEN_S8;
					end else
						rx_cnt_q <= rx_cnt_q - 24'h1;
				end
				sbs_pkg::RX_DATA: begin
					if (rx_tick) begin
						rsh_q    <= {rx_s2_q, rsh_q[8:1]};
						rbits_q  <= rbits_q - 4'h1;
						rx_cnt_q <= bit_cyc;
						if (rbits_q == 4'h1)
							rx_st_q <= sbs_pkg::RX_STOP;
					end else
						rx_cnt_q <= rx_cnt_q - 24'h1;
				end
				sbs_pkg::RX_STOP: begin
					if (rx_tick)
						rx_st_q  <= sbs_pkg::RX_IDLE;
					else
						rx_cnt_q <= rx_cnt_q - 24'h1;
				end
			endcase
		end
	end

	// received byte, framing error and ready flag (set beats read-clear)
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rhr_q  <= sbs_pkg::REG_RST;
			fer_q  <= 1'b0;
			r9d_q  <= 1'b0;
			rrdy_q <= 1'b0;
		end else if (~pen) begin
			fer_q  <= 1'b0;
			rrdy_q <= 1'b0;
		end else begin
			if (rx_st_q == sbs_pkg::RX_STOP && rx_tick) begin
				rhr_q <= rsc_q[sbs_pkg::RSC_R9E] ? rsh_q[7:0] : rsh_q[8:1];
				r9d_q <= rsc_q[sbs_pkg::RSC_R9E] & rsh_q[8];
				fer_q <= ~rx_s2_q;
			end
			rrdy_q <= rrdy_set | (rrdy_q & ~rd_rhr);
		end
	end

endmodule

// *** hw/sbs_pkg.sv ***
package sbs_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam int         ADDR_W  = 5;
	localparam logic [4:0] OFS_TSC = 5'h00; // transmit_status_control
	localparam logic [4:0] OFS_RSC = 5'h04; // receive_status_control
	localparam logic [4:0] OFS_RCR = 5'h08; // rate_control_reg
	localparam logic [4:0] OFS_DVL = 5'h0c; // rate_divisor_low
	localparam logic [4:0] OFS_DVH = 5'h10; // rate_divisor_high
	localparam logic [4:0] OFS_THR = 5'h14; // transmit_holding_reg, write only
	localparam logic [4:0] OFS_RHR = 5'h18; // receive_holding_reg, read only
	localparam logic [4:0] OFS_FLG = 5'h1c; // event flags, read only

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int TSC_MCS = 7; // master_clock_source
	localparam int TSC_NBE = 6; // ninth_bit_enable
	localparam int TSC_TEN = 5; // transmit_enable_bit
	localparam int TSC_CKM = 4; // clocked (synchronous) mode
	localparam int TSC_BRK = 3; // break_request
	localparam int TSC_RHS = 2; // rate_high_speed
	localparam int TSC_SRE = 1; // shift_reg_empty, read only
	localparam int TSC_NTB = 0; // ninth_transmit_bit
	localparam int RSC_PEN = 7; // port_enable_bit
	localparam int RSC_R9E = 6; // ninth receive bit enable
	localparam int RSC_SRX = 5; // single_receive_enable
	localparam int RSC_CRX = 4; // continuous_receive_enable
	localparam int RSC_ADE = 3; // address detect, stored only
	localparam int RSC_FER = 2; // framing_error_flag, read only
	localparam int RSC_R9D = 0; // received ninth bit, read only
	localparam int RCR_IDL = 6; // receiver idle, read only
	localparam int RCR_POL = 4; // clock_polarity_select
	localparam int RCR_WID = 3; // rate_wide_counter
	localparam int RCR_WAK = 1; // wake_on_break_enable
	localparam int RCR_ABD = 0; // autobaud_arm, stored only
	localparam int FLG_TBE = 0; // transmit_buffer_empty_flag
	localparam int FLG_RRD = 1; // receive_ready_flag

	// ------------------------------------------------------------
	// reset values and writable masks
	// ------------------------------------------------------------
	localparam logic [7:0] REG_RST  = 8'h00;
	localparam logic [7:0] TSC_WMSK = 8'hfd;
	localparam logic [7:0] RSC_WMSK = 8'hf8;
	localparam logic [7:0] RCR_WMSK = 8'h1b;

	// ------------------------------------------------------------
	// bit timing: clocks per bit = (divisor + 1) << shift
	// ------------------------------------------------------------
	localparam logic [2:0] SH_SLOW = 3'h6; // x64
	localparam logic [2:0] SH_MID  = 3'h4; // x16
	localparam logic [2:0] SH_FAST = 3'h2; // x4, also the clocked mode rate
	localparam int         CNT_W   = 24;

	// ------------------------------------------------------------
	// frame lengths in bits
	// ------------------------------------------------------------
	localparam int         FRM_W    = 14;
	localparam int         BRK_ZERO = 12;
	localparam logic [3:0] LEN_BRK  = 4'(BRK_ZERO + 2); // start, zeros, stop
	localparam logic [3:0] LEN_A8   = 4'ha;
	localparam logic [3:0] LEN_A9   = 4'hb;
	localparam logic [3:0] LEN_S8   = 4'h8;
	localparam logic [3:0] LEN_S9   = 4'h9;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_ASYNC = 2'b01,
		TX_LEAD  = 2'b10,
		TX_TRAIL = 2'b11
	} sbs_tx_st_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} sbs_rx_st_t;

	// pad driver: value and active-low output enable
	typedef struct packed {
		logic out;
		logic oe_n;
	} sbs_pin_t;

endpackage

// *** verif/sbs_checker.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module sbs_checker (
	input wire logic                       clk,
	input wire logic                       rst,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [sbs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       data_line_in,
	input wire sbs_pkg::sbs_pin_t          data_line_pin,
	input wire sbs_pkg::sbs_pin_t          clock_line_pin
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// pins and bus answers
	AST_RELEASE_IDLE: assert property ($fell(rst) |-> data_line_pin.oe_n && clock_line_pin.oe_n)
		else $error("pin driven right after reset");
	AST_DATA_WITH_CLK: assert property (!data_line_pin.oe_n |-> !clock_line_pin.oe_n)
		else $error("data driven without clock driver");
	AST_DATA_AFTER_EDGE: assert property (!data_line_pin.oe_n && $changed(clock_line_pin.out)
		|=> $stable(data_line_pin.out)) else $error("data moved right after a clock edge");
	AST_HALF_MIN: assert property (!clock_line_pin.oe_n && !data_line_pin.oe_n
		&& $changed(clock_line_pin.out) |=> $stable(clock_line_pin.out))
		else $error("clock phase shorter than two cycles");
	AST_READY_ACCESS: assert property (pready == (psel && penable))
		else $error("ready outside access phase");
	AST_UNMAPPED: assert property (psel && penable && !pwrite && paddr[1:0] != 2'h0
		|-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
	AST_MAPPED_OK: assert property (psel && penable && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	AST_ERR_ONLY_ACCESS: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");

	// main scenarios
	COV_SYNC_TX: cover property (!data_line_pin.oe_n && $changed(clock_line_pin.out));
	COV_REFUSED: cover property (pslverr);
	COV_ASYNC_START: cover property (data_line_pin.oe_n && $fell(clock_line_pin.out));
endmodule

bind sbs_top sbs_checker sbs_checker_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .data_line_in(data_line_in), .data_line_pin(data_line_pin),
	.clock_line_pin(clock_line_pin));

// *** verif/sbs_slave_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// far side: clocked slave and async line node
// ------------------------------------------------------------
module sbs_slave_model #(
	parameter int BIT_CYC = 4
) (
	input  wire logic              clk,
	input  wire logic              pol,
	input  wire sbs_pkg::sbs_pin_t data_line_pin,
	input  wire sbs_pkg::sbs_pin_t clock_line_pin,
	output      logic              data_line_in
);
	logic drv_q   = 1'b1;
	logic ck_prev = 1'b0;
	logic lead_q  = 1'b0;
	logic stuck   = 1'b0;
	logic rx[$];

	// shared data line, pulled high when nobody drives
	assign data_line_in = data_line_pin.oe_n ? drv_q : data_line_pin.out;

	// capture on a trailing edge that follows a leading edge, so a mode
	// switch that moves the idle clock level is not taken for a bit
	always @(negedge clk) begin
		if (clock_line_pin.oe_n || data_line_pin.oe_n) begin
			lead_q = 1'b0;
		end else if (clock_line_pin.out !== ck_prev && clock_line_pin.out !== pol) begin
			lead_q = 1'b1;
		end else if (clock_line_pin.out !== ck_prev && lead_q) begin
			rx.push_back(data_line_pin.out);
			lead_q = 1'b0;
		end
		ck_prev = clock_line_pin.out;
	end

	// one async frame, lsb first, chosen stop level
	task automatic send_async(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			drv_q <= f[i];
			repeat (BIT_CYC - 1) @(posedge clk);
		end
		@(posedge clk);
		drv_q <= 1'b1;
	endtask

	// sample async bits sent on the clock pin, mid bit
	task automatic get_async(input int n, output logic [23:0] bits);
		int k;
		bits = 24'h0;
		k = 0;
		while (clock_line_pin.out !== 1'b0 && k < 4000) begin
			@(negedge clk);
			k++;
		end
		if (k == 4000)
			stuck = 1'b1;
		repeat (BIT_CYC / 2) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			bits[i] = clock_line_pin.out;
			repeat (BIT_CYC) @(negedge clk);
		end
	endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic                  clk     = 1'b0;
	logic                  rst     = 1'b1;
	logic                  psel    = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite  = 1'b0;
	logic [4:0]            paddr   = 5'h00;
	logic [31:0]           pwdata  = 32'h0;
	logic                  pol     = 1'b0;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  data_line_in;
	sbs_pkg::sbs_pin_t     data_line_pin;
	sbs_pkg::sbs_pin_t     clock_line_pin;
	int                    fails = 0;
	int                    total_checks = 0;
	logic [31:0]           rd;
	logic                  er;
	logic [23:0]           bits;
	logic [15:0]           v;

	always #2.5 clk = ~clk;

	sbs_top sbs_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.data_line_in(data_line_in), .data_line_pin(data_line_pin),
		.clock_line_pin(clock_line_pin));
	sbs_slave_model #(.BIT_CYC(4)) sbs_slave_model_i (.clk(clk), .pol(pol),
		.data_line_pin(data_line_pin), .clock_line_pin(clock_line_pin),
		.data_line_in(data_line_in));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic final_report();
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask

	// one bus transfer, held until ready
	task automatic apb(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n == 50) begin
			fails++;
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rc(input logic [4:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		check(rd, {24'h0, e});
	endtask

	// read until a flag shows, bounded
	task automatic poll(input logic [4:0] a, input logic [7:0] m);
		int n;
		n = 0;
		apb(1'b0, a, 8'h00);
		while ((rd[7:0] & m) !== m && n < 400) begin
			apb(1'b0, a, 8'h00);
			n++;
		end
		if (n == 400) begin
			fails++;
			final_report();
		end
	endtask

	// wait for captured bits and pack them lsb first
	task automatic take_bits(input int k);
		int n;
		n = 0;
		while (sbs_slave_model_i.rx.size() < k && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n == 2000) begin
			fails++;
			final_report();
		end
		v = 16'h0;
		for (int i = 0; i < k && sbs_slave_model_i.rx.size() > 0; i++)
			v[i] = sbs_slave_model_i.rx.pop_front();
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rc(sbs_pkg::OFS_TSC, 8'h02);
		rc(sbs_pkg::OFS_FLG, 8'h01);
		rc(sbs_pkg::OFS_THR, 8'h00);
		apb(1'b0, 5'h02, 8'h00);
		check({31'h0, er}, 32'h1);
		wr(sbs_pkg::OFS_DVH, 8'ha5);
		rc(sbs_pkg::OFS_DVH, 8'ha5);
		wr(sbs_pkg::OFS_DVH, 8'h00);
		// clocked master, two bytes back to back
		wr(sbs_pkg::OFS_DVL, 8'h00);
		wr(sbs_pkg::OFS_RSC, 8'h80);
		wr(sbs_pkg::OFS_TSC, 8'hb0);
		wr(sbs_pkg::OFS_THR, 8'ha5);
		poll(sbs_pkg::OFS_FLG, 8'h01);
		wr(sbs_pkg::OFS_THR, 8'h3c);
		rc(sbs_pkg::OFS_TSC, 8'hb0);
		check({31'h0, data_line_pin.oe_n}, 32'h0);
		check({31'h0, clock_line_pin.oe_n}, 32'h0);
		take_bits(16);
		check({16'h0, v}, 32'h3ca5);
		repeat (64) @(posedge clk);
		check(sbs_slave_model_i.rx.size(), 32'h0);
		rc(sbs_pkg::OFS_TSC, 8'hb2);
		// idle-high clock, nine bits
		wr(sbs_pkg::OFS_TSC, 8'hf1);
		pol <= 1'b1;
		wr(sbs_pkg::OFS_RCR, 8'h10);
		repeat (2) @(posedge clk);
		check({31'h0, clock_line_pin.out}, 32'h1);
		wr(sbs_pkg::OFS_THR, 8'h5a);
		take_bits(9);
		check({16'h0, v}, 32'h015a);
		// a receive enable holds the byte back
		wr(sbs_pkg::OFS_RSC, 8'h90);
		wr(sbs_pkg::OFS_THR, 8'h11);
		repeat (20) @(posedge clk);
		rc(sbs_pkg::OFS_FLG, 8'h00);
		check({31'h0, data_line_pin.oe_n}, 32'h1);
		wr(sbs_pkg::OFS_RSC, 8'h00);
		rc(sbs_pkg::OFS_FLG, 8'h01);
		check(sbs_slave_model_i.rx.size(), 32'h0);
		// break then sync byte, async
		wr(sbs_pkg::OFS_TSC, 8'h2c);
		wr(sbs_pkg::OFS_RCR, 8'h08);
		wr(sbs_pkg::OFS_RSC, 8'h80);
		fork
			sbs_slave_model_i.get_async(24, bits);
			begin
				wr(sbs_pkg::OFS_THR, 8'hff);
				poll(sbs_pkg::OFS_FLG, 8'h01);
				wr(sbs_pkg::OFS_THR, 8'h55);
				rc(sbs_pkg::OFS_TSC, 8'h2c);
			end
		join
		if (sbs_slave_model_i.stuck) begin
			fails++;
			final_report();
		end
		check({8'h0, bits}, {8'h0, 1'b1, 8'h55, 1'b0, 1'b1, 13'h0000});
		repeat (8) @(posedge clk);
		rc(sbs_pkg::OFS_TSC, 8'h26);
		// break arriving from the line
		wr(sbs_pkg::OFS_RSC, 8'h90);
		sbs_slave_model_i.send_async(8'h00, 1'b0);
		poll(sbs_pkg::OFS_FLG, 8'h02);
		rc(sbs_pkg::OFS_RSC, 8'h94);
		rc(sbs_pkg::OFS_RHR, 8'h00);
		rc(sbs_pkg::OFS_FLG, 8'h01);
		// wake on break with autobaud armed, then a normal byte
		wr(sbs_pkg::OFS_RCR, 8'h0b);
		sbs_slave_model_i.send_async(8'h00, 1'b0);
		repeat (4) @(posedge clk);
		rc(sbs_pkg::OFS_FLG, 8'h03);
		rc(sbs_pkg::OFS_RCR, 8'h49);
		rc(sbs_pkg::OFS_RHR, 8'h00);
		sbs_slave_model_i.send_async(8'h3c, 1'b1);
		poll(sbs_pkg::OFS_FLG, 8'h02);
		rc(sbs_pkg::OFS_RHR, 8'h3c);
		rc(sbs_pkg::OFS_RSC, 8'h90);
		final_report();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		final_report();
	end
endmodule
